/* inc/aux_pin_map.svh */
`ifndef AUX_PIN_MAP_SVH
`define AUX_PIN_MAP_SVH

// register indices; the byte address on the bus is four times the index
`define PINS_5_6_SETUP_IDX 6'h20
`define PINS_7_8_SETUP_IDX 6'h21
`define PAD_LEVEL_IDX 6'h26
`define PAD_DRIVE_IDX 6'h27

// field positions of the upper pin (6 and 8) in a setup register
`define HI_LEVEL_BIT 7
`define HI_DIR_BIT 5
`define HI_EN_BIT 4

// field positions of the lower pin (5 and 7) in a setup register
`define LO_LEVEL_BIT 3
`define LO_DIR_BIT 1
`define LO_EN_BIT 0

// reset values
`define SETUP_RESET 8'h00
`define READ_RESET 32'h0000_0000

// avalon response codes
`define RESP_OKAY 2'h0
`define RESP_DECODE_ERR 2'h3

`endif

/* inc/aux_pin_pkg.sv */
`default_nettype none

package aux_pin_pkg;

   // pad mode, coded as {direction, function select}
   typedef enum logic [1:0] {
      PAD_FUNC_OUT = 2'b00,
      PAD_GPIO_OUT = 2'b01,
      PAD_TRISTATE = 2'b10,
      PAD_GPIO_IN = 2'b11
   } pad_mode_e;

   // register bus handshake state
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } bus_state_e;

endpackage

`default_nettype wire

/* design/pin_pad_ctrl.sv */
`default_nettype none

module pin_pad_ctrl
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire aux_pin_pkg::pad_mode_e mode,
   input wire logic drive_level,
   input wire logic func_level,
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   output logic in_level
);
   import aux_pin_pkg::*;

   logic pad_out_d;
   logic pad_oe_d;

   // decode the pad mode into drive value and enable
   always_comb
   begin
      pad_out_d = 1'b0;
      pad_oe_d = 1'b0;
      case (mode)
         PAD_FUNC_OUT:
         begin
            pad_out_d = func_level; // (R1)
            pad_oe_d = 1'b1; // (R1)
         end
         PAD_GPIO_OUT:
         begin
            // no remote control exists for these pins, so it is always off
            pad_out_d = drive_level; // (R2)
            pad_oe_d = 1'b1; // (R1)
         end
         PAD_TRISTATE:
         begin
            pad_oe_d = 1'b0; // (R1)
         end
         PAD_GPIO_IN:
         begin
            pad_oe_d = 1'b0; // (R1)
         end
         default:
         begin
            pad_oe_d = 1'b0;
         end
      endcase
   end

   // registered pad drive, so pins never see decode glitches
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
      end
      else
      begin
         pad_out <= pad_out_d;
         pad_oe <= pad_oe_d;
      end
   end

   // pad level sampled every cycle; input is synchronous to clk_sys
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         in_level <= 1'b0;
      end
      else
      begin
         in_level <= pad_in;
      end
   end

endmodule

`default_nettype wire

/* design/aux_pin_config_bank.sv */
`include "aux_pin_map.svh"
`default_nettype none
// How it works
// (R1) pin code {dir,en}: 00 functional out, 10 tri-state, 01 gpio out, 11 in
// (R2) drive level reaches the pin only in gpio output mode, no remote control
// (R3) upper pins 6 and 8: level bit 7, direction bit 5, select bit 4
// (R4) lower pins 5 and 7: level bit 3, direction bit 1, select bit 0
// (R5) pins 5 and 6 setup sits at index 0x20, all bits reset to zero
// (R6) pins 7 and 8 setup sits at index 0x21, same layout, reset zero
// (R7) software writes zero to reserved bits 6 and 2, expects no effect

module aux_pin_config_bank
#(
   parameter int ADDR_W = 8
)
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   input wire logic [3:0] func_level,
   input wire logic [3:0] pin_in,
   output logic [3:0] pin_out,
   output logic [3:0] pin_oe
);
   import aux_pin_pkg::*;

   bus_state_e bus_state_q;
   bus_state_e bus_state_d;
   logic [7:0] pins_5_6_setup_q;
   logic [7:0] pins_7_8_setup_q;
   logic [5:0] word_idx;
   logic aligned;
   logic hit_5_6;
   logic hit_7_8;
   logic hit_level;
   logic hit_drive;
   logic hit_any;
   logic wr_commit;
   logic req_taken;
   logic wr_5_6;
   logic wr_7_8;
   logic upper_clear;
   logic [31:0] rd_word;
   logic [1:0] rd_resp;
   logic [3:0] pin_level;
   logic [3:0] pin_drive_level;
   pad_mode_e pin_mode [0:3];

   // the word index is the byte address with the lane bits dropped
   assign word_idx = avs_address[7:2];
   assign aligned = (avs_address[1:0] == 2'b00);

   // bits above the map must be zero, else a wide bus would alias the map
   generate
      if (ADDR_W > 8)
      begin : g_wide_addr
         assign upper_clear = (avs_address[ADDR_W-1:8] == '0);
      end
      else
      begin : g_narrow_addr
         assign upper_clear = 1'b1;
      end
   endgenerate

   // address decode; only aligned words inside the map are hits
   always_comb
   begin
      hit_5_6 = 1'b0;
      hit_7_8 = 1'b0;
      hit_level = 1'b0;
      hit_drive = 1'b0;
      if (!aligned || !upper_clear)
      begin
         hit_5_6 = 1'b0;
      end
      else if (word_idx == `PINS_5_6_SETUP_IDX) // (R5)
      begin
         hit_5_6 = 1'b1;
      end
      else if (word_idx == `PINS_7_8_SETUP_IDX) // (R6)
      begin
         hit_7_8 = 1'b1;
      end
      else if (word_idx == `PAD_LEVEL_IDX)
      begin
         hit_level = 1'b1;
      end
      else if (word_idx == `PAD_DRIVE_IDX)
      begin
         hit_drive = 1'b1;
      end
   end

   assign hit_any = hit_5_6 | hit_7_8 | hit_level | hit_drive;

   // a write lands at the edge where the master sees waitrequest low
   assign wr_commit = (bus_state_q == BUS_ACK) && avs_write;

   // a request is taken at the idle edge; data and response load there
   assign req_taken = (bus_state_q == BUS_IDLE) && (avs_read || avs_write);

   // write strobes; only lane 0 carries a setup byte, misses change nothing
   always_comb
   begin
      wr_5_6 = 1'b0;
      wr_7_8 = 1'b0;
      if (!wr_commit || !hit_any || !avs_byteenable[0])
      begin
         wr_5_6 = 1'b0;
      end
      else if (hit_5_6)
      begin
         wr_5_6 = 1'b1; // (R5)
      end
      else if (hit_7_8)
      begin
         wr_7_8 = 1'b1; // (R6)
      end
   end

   // read mux; data narrower than the bus sits low, upper bits are zero
   always_comb
   begin
      rd_word = `READ_RESET;
      rd_resp = `RESP_OKAY;
      if (hit_5_6)
      begin
         rd_word = {24'h00_0000, pins_5_6_setup_q};
      end
      else if (hit_7_8)
      begin
         rd_word = {24'h00_0000, pins_7_8_setup_q};
      end
      else if (hit_level)
      begin
         rd_word = {28'h000_0000, pin_level};
      end
      else if (hit_drive)
      begin
         rd_word = {24'h00_0000, pin_oe, pin_out};
      end
      else
      begin
         // unmapped reads answer zero with a decode error
         rd_resp = `RESP_DECODE_ERR;
      end
   end

   // one wait state: idle sees the request, ack releases waitrequest
   always_comb
   begin
      bus_state_d = bus_state_q;
      case (bus_state_q)
         BUS_IDLE:
         begin
            if (avs_read || avs_write)
            begin
               bus_state_d = BUS_ACK;
            end
         end
         BUS_ACK:
         begin
            bus_state_d = BUS_IDLE;
         end
         default:
         begin
            bus_state_d = BUS_IDLE;
         end
      endcase
   end

   // handshake state
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         bus_state_q <= BUS_IDLE;
      end
      else
      begin
         bus_state_q <= bus_state_d;
      end
   end

   // waitrequest is high in reset so nothing is taken early
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         avs_waitrequest <= 1'b1;
      end
      else
      begin
         avs_waitrequest <= (bus_state_d != BUS_ACK);
      end
   end

   // read data latched on entry to ack, held until the next read request
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         avs_readdata <= `READ_RESET;
      end
      else if (req_taken && avs_read)
      begin
         avs_readdata <= rd_word;
      end
   end

   // response follows the decode for reads and writes alike
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         avs_response <= `RESP_OKAY;
      end
      else if (req_taken)
      begin
         avs_response <= rd_resp;
      end
   end

   // pins 5 and 6 setup; reserved bits are stored as plain storage
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         pins_5_6_setup_q <= `SETUP_RESET; // (R5)
      end
      else if (wr_5_6)
      begin
         pins_5_6_setup_q <= avs_writedata[7:0]; // (R5)
      end
   end

   // pins 7 and 8 setup, same layout as the 5 and 6 register
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         pins_7_8_setup_q <= `SETUP_RESET; // (R6)
      end
      else if (wr_7_8)
      begin
         pins_7_8_setup_q <= avs_writedata[7:0]; // (R6)
      end
   end

   // per-pin field extraction and pad control; reserved bits feed nothing
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_pin
         logic [7:0] cfg;
         logic dir_bit;
         logic sel_bit;

         // pins 5 and 6 come from the first register, 7 and 8 the second
         assign cfg = (g < 2) ? pins_5_6_setup_q : pins_7_8_setup_q;

         if ((g % 2) == 1)
         begin : g_upper
            assign dir_bit = cfg[`HI_DIR_BIT]; // (R3)
            assign sel_bit = cfg[`HI_EN_BIT]; // (R3)
            assign pin_drive_level[g] = cfg[`HI_LEVEL_BIT]; // (R3)
         end
         else
         begin : g_lower
            assign dir_bit = cfg[`LO_DIR_BIT]; // (R4)
            assign sel_bit = cfg[`LO_EN_BIT]; // (R4)
            assign pin_drive_level[g] = cfg[`LO_LEVEL_BIT]; // (R4)
         end

         assign pin_mode[g] = pad_mode_e'({dir_bit, sel_bit}); // (R1)

         pin_pad_ctrl pin_pad_ctrl_i
         (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .mode(pin_mode[g]),
            .drive_level(pin_drive_level[g]),
            .func_level(func_level[g]),
            .pad_in(pin_in[g]),
            .pad_out(pin_out[g]),
            .pad_oe(pin_oe[g]),
            .in_level(pin_level[g])
         );
      end
   endgenerate

endmodule

`default_nettype wire

/* verif/aux_pin_checker.sv */
`default_nettype none
module aux_pin_checker
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response,
   input wire logic [3:0] func_level,
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic done, wr;
   logic [7:0] lo_q, hi_q;
   logic [3:0] dir, sel, lvl, exp_out;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // expected pad state from the shadowed setup fields
   assign done = !avs_waitrequest && (avs_read || avs_write);
   assign wr = done && avs_write && avs_byteenable[0];
   assign dir = {hi_q[5], hi_q[1], lo_q[5], lo_q[1]};
   assign sel = {hi_q[4], hi_q[0], lo_q[4], lo_q[0]};
   assign lvl = {hi_q[7], hi_q[3], lo_q[7], lo_q[3]};
   assign exp_out = ~dir & ((sel & lvl) | (~sel & func_level));
   // shadow copies, updated at the edge that completes a write
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         lo_q <= 8'h00;
         hi_q <= 8'h00;
      end
      else if (wr && avs_address == 8'h80)
         lo_q <= avs_writedata[7:0];
      else if (wr && avs_address == 8'h84)
         hi_q <= avs_writedata[7:0];
   end
   a_req_acked: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("request not acked");
   a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("ack longer than one cycle");
   a_oe_decode: assert property ($past(rstn) |-> pin_oe == ~$past(dir))
      else $error("pad enable wrong");
   a_out_level: assert property ($past(rstn) |-> pin_out == $past(exp_out))
      else $error("pad drive wrong");
   a_rd_lo: assert property (done && avs_read && avs_address == 8'h80
      |-> avs_readdata == {24'h0, lo_q} && avs_response == 2'h0)
      else $error("pins 5 6 readback wrong");
   a_rd_hi: assert property (done && avs_read && avs_address == 8'h84
      |-> avs_readdata == {24'h0, hi_q} && avs_response == 2'h0)
      else $error("pins 7 8 readback wrong");
   a_bad_addr: assert property (done && !(avs_address inside
      {8'h80, 8'h84, 8'h98, 8'h9c}) |-> avs_response == 2'h3)
      else $error("unmapped access not refused");
   c_wr_hi: cover property (wr && avs_address == 8'h84);
   c_all_off: cover property (pin_oe == 4'h0);
   c_refused: cover property (done && avs_response == 2'h3);
endmodule
`default_nettype wire

/* verif/aux_pin_config_bank_test.sv */
`default_nettype none
module aux_pin_config_bank_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest;
   logic [7:0] avs_address, lo, hi;
   logic [31:0] avs_writedata, avs_readdata, q, d;
   logic [3:0] avs_byteenable, func_level, pin_in, pin_out, pin_oe;
   logic [1:0] avs_response, r;
   int err_count, checked, cyc, seed;
   aux_pin_config_bank aux_pin_config_bank_i (.clk_sys, .rstn, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .avs_response, .func_level, .pin_in, .pin_out,
      .pin_oe);
   // 200 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // one bus cycle; the leading edge keeps release and raise apart
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [7:0] v, input logic [3:0] be);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= {24'h0, v};
      avs_byteenable <= be;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk_sys);
      q = avs_readdata;
      r = avs_response;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // expected {pin_oe, pin_out} for two setup bytes
   function automatic logic [7:0] pads(input logic [7:0] s, input logic [7:0] t,
      input logic [3:0] f);
      logic [3:0] dr, sl, lv;
      dr = {t[5], t[1], s[5], s[1]};
      sl = {t[4], t[0], s[4], s[0]};
      lv = {t[7], t[3], s[7], s[3]};
      return {~dr, ~dr & ((sl & lv) | (~sl & f))};
   endfunction
   task results;
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // cut a hang short well past the expected run length
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         results;
      end
   end
   initial
   begin
      {rstn, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {avs_byteenable, func_level, pin_in, err_count, checked, cyc} = '0;
      seed = 3547;
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      bus(0, 8'h80, 8'h00, 4'h1);
      cmp(q, 0);
      bus(0, 8'h84, 8'h00, 4'h1);
      cmp(q, 0);
      $display("test reset values done");
      // first four rounds put every pin in one mode code
      for (int i = 0; i < 12; i++)
      begin
         d = $random(seed);
         lo = d[7:0] & 8'hbb;
         hi = d[15:8] & 8'hbb;
         if (i < 4)
         begin
            lo = (lo & 8'h88) | (8'(i) * 8'h11);
            hi = (hi & 8'h88) | (8'(i) * 8'h11);
         end
         func_level <= d[19:16];
         pin_in <= d[23:20];
         bus(1, 8'h80, lo, 4'h1);
         bus(1, 8'h84, hi, 4'h1);
         bus(0, 8'h80, 8'h00, 4'h1);
         cmp(q, {24'h0, lo});
         bus(0, 8'h84, 8'h00, 4'h1);
         cmp(q, {24'h0, hi});
         bus(0, 8'h98, 8'h00, 4'h1);
         cmp(q, {28'h0, pin_in});
         bus(0, 8'h9c, 8'h00, 4'h1);
         cmp(q, {24'h0, pads(lo, hi, func_level)});
         #1 cmp({pin_oe, pin_out}, pads(lo, hi, func_level));
      end
      $display("test pad modes done");
      // masked lane write is ignored, unmapped and unaligned places are refused
      bus(1, 8'h80, 8'hff, 4'he);
      bus(0, 8'h80, 8'h00, 4'h1);
      cmp(q, {24'h0, lo});
      bus(1, 8'h88, 8'hff, 4'h1);
      cmp(r, 2'h3);
      bus(0, 8'h81, 8'h00, 4'h1);
      cmp(q, 0);
      cmp(r, 2'h3);
      rstn <= 1'b0;
      @(posedge clk_sys);
      rstn <= 1'b1;
      bus(0, 8'h84, 8'h00, 4'h1);
      cmp(q, 0);
      bus(0, 8'h80, 8'h00, 4'h1);
      cmp(q, 0);
      $display("test refusals and reset done");
      results;
   end
endmodule
bind aux_pin_config_bank aux_pin_checker aux_pin_checker_i (.clk_sys, .rstn,
   .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
   .avs_readdata, .avs_waitrequest, .avs_response, .func_level, .pin_out,
   .pin_oe);
`default_nettype wire
